//--- include/tcc_pkg.sv
// constants, encodings and helpers shared by the timer channel control block
package tcc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TCC_OFS_CHCTL = 8'h18;
    localparam logic [7:0] TCC_OFS_ENABLE = 8'h20;
    localparam logic [7:0] TCC_OFS_CV0 = 8'h34;
    localparam logic [7:0] TCC_OFS_CV1 = 8'h38;
    localparam logic [7:0] TCC_OFS_PROTECTION_LEVEL = 8'h44;
    localparam logic [7:0] TCC_OFS_STATUS = 8'h48;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TCC_RST_CHFIELD = 8'h00;
    localparam logic [7:0] TCC_RST_ENABLE = 8'h00;
    localparam logic [1:0] TCC_RST_PROTECTION_LEVEL = 2'h0;
    localparam logic [15:0] TCC_RST_CV = 16'h0000;
    localparam logic [1:0] TCC_RST_WAIT = 2'h1;

    // ------------------------------------------------------------
    // channel control field layout (per channel byte, ch1 at +8)
    // ------------------------------------------------------------
    localparam int TCC_CH1_LSB = 8;
    localparam int TCC_MODE_LSB = 0;
    localparam int TCC_FAST_BIT = 2;
    localparam int TCC_SHADOW_BIT = 3;
    localparam int TCC_CTL_LSB = 4;
    localparam int TCC_PSC_LSB = 2;
    localparam int TCC_FLT_LSB = 4;
    localparam int TCC_OUT_RSVD_BIT = 7;

    // enable / polarity register bits, per channel at +4
    localparam int TCC_EN_STRIDE = 4;
    localparam int TCC_EN_BIT = 0;
    localparam int TCC_POL_BIT = 1;
    localparam int TCC_NPOL_BIT = 3;

    localparam logic [1:0] TCC_PROTECTION_LEVEL_FULL = 2'h3;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TCC_MS_OUTPUT = 2'h0,
        TCC_MS_OWN = 2'h1,
        TCC_MS_OTHER = 2'h2,
        TCC_MS_TRIG = 2'h3
    } tcc_mode_t;

    typedef enum logic [2:0] {
        TCC_OC_TIMING = 3'h0,
        TCC_OC_SET = 3'h1,
        TCC_OC_CLEAR = 3'h2,
        TCC_OC_TOGGLE = 3'h3,
        TCC_OC_FLOW = 3'h4,
        TCC_OC_FHIGH = 3'h5,
        TCC_OC_PWM0 = 3'h6,
        TCC_OC_PWM1 = 3'h7
    } tcc_compare_t;

    // ------------------------------------------------------------
    // filter code decode: samples needed and sample divider
    // ------------------------------------------------------------
    function automatic logic [3:0] tcc_filt_samples(input logic [3:0] code);
        logic [3:0] n;
        n = 4'h8;
        unique case (code)
            4'h1: n = 4'h2;
            4'h2: n = 4'h4;
            4'h4, 4'h6, 4'h8: n = 4'h6;
            default: n = 4'h8;
        endcase
        return n;
    endfunction

    // log2 of the divider applied to the filter sampling clock (clk_sys here)
    function automatic logic [1:0] tcc_filt_div_log(input logic [3:0] code);
        logic [1:0] d;
        d = 2'h0;
        unique case (code)
            4'h4, 4'h5: d = 2'h1;
            4'h6, 4'h7: d = 2'h2;
            4'h8, 4'h9: d = 2'h3;
            default: d = 2'h0;
        endcase
        return d;
    endfunction

endpackage

//--- src/tcc_filter.sv
// input capture digital filter for one channel input
`timescale 1ns/1ps
`default_nettype none
module tcc_filter
    import tcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic din,
    input wire logic [3:0] code,
    output logic dout
);

    logic [2:0] div_reg;
    logic [3:0] cnt_reg;
    logic sample_en;
    logic [1:0] dlog;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    always_comb begin
        dlog = tcc_filt_div_log(code);
        unique case (dlog)
            2'h1: sample_en = (div_reg[0] == 1'b1);
            2'h2: sample_en = (div_reg[1:0] == 2'h3);
            2'h3: sample_en = (div_reg == 3'h7);
            default: sample_en = 1'b1;
        endcase
    end

    // for a nonzero code a level is taken only after the required run of equal samples
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_reg <= 4'h0;
            dout <= 1'b0;
        end else if (code == 4'h0) begin
            cnt_reg <= 4'h0;
            dout <= din;
        end else if (sample_en) begin
            if (din == dout) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg + 4'h1 >= tcc_filt_samples(code)) begin
                cnt_reg <= 4'h0;
                dout <= din;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

endmodule
`default_nettype wire

//--- src/tcc_compare.sv
// compare value shadowing and output prepare generation for one channel
`timescale 1ns/1ps
`default_nettype none
module tcc_compare
    import tcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [2:0] compare_control,
    input wire logic shadow_en,
    input wire logic fast_en,
    input wire logic output_mode,
    input wire logic [15:0] counter_value,
    input wire logic count_down,
    input wire logic update_event,
    input wire logic trigger_edge,
    input wire logic cv_write,
    input wire logic [15:0] cv_wdata,
    input wire logic capture,
    output logic prepare,
    output logic [15:0] cv_active
);

    logic [15:0] cv_shadow_reg;
    logic cmp_prev_reg;
    logic [2:0] ctl_prev_reg;
    logic match;
    logic cmp_now;
    logic pwm_level;
    logic pwm_match_level;
    logic pwm_mode;

    // ------------------------------------------------------------
    // compare value: shadow copy or direct
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cv_shadow_reg <= TCC_RST_CV;
            cv_active <= TCC_RST_CV;
        end else if (capture) begin
            cv_active <= counter_value;
        end else begin
            if (cv_write) begin
                cv_shadow_reg <= cv_wdata;
            end
            if (cv_write && !shadow_en) begin
                cv_active <= cv_wdata;
            end else if (update_event && shadow_en) begin
                cv_active <= cv_shadow_reg;
            end
        end
    end

    always_comb begin
        match = (counter_value == cv_active);
        cmp_now = count_down ? (counter_value > cv_active) : (counter_value < cv_active);
        pwm_mode = (compare_control == TCC_OC_PWM0) || (compare_control == TCC_OC_PWM1);
        // pwm0: up -> high below; down -> low above
        pwm_level = (compare_control == TCC_OC_PWM0) ? (cmp_now ^ count_down)
                                                     : ~(cmp_now ^ count_down);
        // level the pwm output takes just after a match
        pwm_match_level = (compare_control == TCC_OC_PWM0) ? count_down : ~count_down;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmp_prev_reg <= 1'b0;
            ctl_prev_reg <= 3'h0;
        end else begin
            cmp_prev_reg <= cmp_now;
            ctl_prev_reg <= compare_control;
        end
    end

    // ------------------------------------------------------------
    // output prepare, active high
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prepare <= 1'b0;
        end else if (output_mode) begin
            unique case (compare_control)
                TCC_OC_TIMING: prepare <= prepare;
                TCC_OC_SET: prepare <= match ? 1'b1 : prepare;
                TCC_OC_CLEAR: prepare <= match ? 1'b0 : prepare;
                TCC_OC_TOGGLE: prepare <= match ? ~prepare : prepare;
                TCC_OC_FLOW: prepare <= 1'b0;
                TCC_OC_FHIGH: prepare <= 1'b1;
                default: begin
                    if (pwm_mode && fast_en && trigger_edge) begin
                        prepare <= pwm_match_level;
                    end else if (ctl_prev_reg == TCC_OC_TIMING || cmp_now != cmp_prev_reg) begin
                        prepare <= pwm_level;
                    end
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- src/tcc_top.sv
// timer channel 0/1 mode, compare and capture control with avalon-mm registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - ch0 mode: 00 output, 01 own input, 10 ch1 input, 11 internal trigger.
// - ch1 mode: 00 output, 01 own input, 10 ch0 input, 11 internal trigger.
// - a mode field takes writes only while its channel enable is clear.
// - code 000 holds the output prepare level steady.
// - 001 sets, 010 clears, 011 toggles the prepare signal on counter match.
// - 100 forces prepare low, 101 forces it high.
// - pwm0: up high below compare; down low above compare.
// - pwm1: up low below compare; down high above compare.
// - pwm level moves only on entry from timing, on comparison change or on a fast-enable trigger edge.
// - prepare is active high; pins apply output and complementary polarity.
// - compare control and shadow enable locked at protection 11 in output mode.
// - shadow on: writes wait for update event; off: immediate.
// - fast enable in pwm: trigger edge acts as match immediately.
// - ch1 fields sit at 14:12, 11, 10, 9:8 and act like ch0.
// - filter accepts a new level after the configured run of equal samples.
// - filter codes choose bypass, sample count and sampling divider.
// - capture prescaler 1/2/4/8 edges; cleared while channel disabled.
module tcc_top
    import tcc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [15:0] COUNTER_VALUE,
    input wire logic COUNT_DOWN,
    input wire logic UPDATE_EVENT,
    input wire logic TRIGGER_EDGE,
    input wire logic INTERNAL_TRIGGER_SOURCE,
    input wire logic CH0_IN,
    input wire logic CH1_IN,
    output logic CH0_OUTPUT_PIN,
    output logic CH0_COMPL_OUTPUT_PIN,
    output logic CH1_OUTPUT_PIN,
    output logic CH1_COMPL_OUTPUT_PIN,
    output logic CH0_CAPTURE,
    output logic CH1_CAPTURE
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] chfield_reg [2];
    logic [7:0] enable_reg;
    logic [1:0] protection_level_reg;
    logic wait_reg;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] src_prev_reg;
    logic [2:0] psc_cnt_reg [2];
    logic [1:0] capture_reg;

    logic [1:0] filtered;
    logic [1:0] prepare;
    logic [15:0] cv_active [2];
    logic [1:0] src_level;
    logic [1:0] src_edge;
    logic [1:0] cv_write;
    logic [1:0] ch_en;
    logic [1:0] ch_pol;
    logic [1:0] ch_npol;
    logic [1:0] out_mode;
    logic access;
    logic wr_take;
    logic word_write;
    logic [31:0] rd_next;

    function automatic logic [1:0] ch_mode(input logic [7:0] f);
        return f[TCC_MODE_LSB +: 2];
    endfunction

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ch_en[i] = enable_reg[i * TCC_EN_STRIDE + TCC_EN_BIT];
            ch_pol[i] = enable_reg[i * TCC_EN_STRIDE + TCC_POL_BIT];
            ch_npol[i] = enable_reg[i * TCC_EN_STRIDE + TCC_NPOL_BIT];
            out_mode[i] = (ch_mode(chfield_reg[i]) == TCC_MS_OUTPUT);
        end
    end

    // ------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then the access completes
    // ------------------------------------------------------------
    assign access = AVS_READ || AVS_WRITE;
    assign wr_take = AVS_WRITE && !wait_reg;
    // partial-word writes are dropped so no field is half updated
    assign word_write = wr_take && (AVS_BYTEENABLE == 4'hf);

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            wait_reg <= TCC_RST_WAIT[0];
        end else if (access && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    assign AVS_WAITREQUEST = wait_reg;

    // ------------------------------------------------------------
    // channel control register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            chfield_reg[0] <= TCC_RST_CHFIELD;
            chfield_reg[1] <= TCC_RST_CHFIELD;
        end else if (word_write && AVS_ADDRESS == TCC_OFS_CHCTL) begin
            for (int i = 0; i < 2; i++) begin
                if (!ch_en[i]) begin
                    chfield_reg[i][TCC_MODE_LSB +: 2] <=
                        AVS_WRITEDATA[i * TCC_CH1_LSB + TCC_MODE_LSB +: 2];
                end
                chfield_reg[i][TCC_FAST_BIT] <= AVS_WRITEDATA[i * TCC_CH1_LSB + TCC_FAST_BIT];
                chfield_reg[i][TCC_OUT_RSVD_BIT] <=
                    AVS_WRITEDATA[i * TCC_CH1_LSB + TCC_OUT_RSVD_BIT];
                if (!(protection_level_reg == TCC_PROTECTION_LEVEL_FULL && out_mode[i])) begin
                    chfield_reg[i][TCC_SHADOW_BIT] <=
                        AVS_WRITEDATA[i * TCC_CH1_LSB + TCC_SHADOW_BIT];
                    chfield_reg[i][TCC_CTL_LSB +: 3] <=
                        AVS_WRITEDATA[i * TCC_CH1_LSB + TCC_CTL_LSB +: 3];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // enable/polarity and protection registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            enable_reg <= TCC_RST_ENABLE;
        end else if (word_write && AVS_ADDRESS == TCC_OFS_ENABLE) begin
            enable_reg <= AVS_WRITEDATA[7:0] & 8'hbb;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            protection_level_reg <= TCC_RST_PROTECTION_LEVEL;
        end else if (word_write && AVS_ADDRESS == TCC_OFS_PROTECTION_LEVEL) begin
            protection_level_reg <= AVS_WRITEDATA[1:0];
        end
    end

    assign cv_write[0] = word_write && (AVS_ADDRESS == TCC_OFS_CV0);
    assign cv_write[1] = word_write && (AVS_ADDRESS == TCC_OFS_CV1);

    // ------------------------------------------------------------
    // read path; unmapped addresses read zero
    // ------------------------------------------------------------
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (AVS_ADDRESS)
            TCC_OFS_CHCTL: begin
                for (int i = 0; i < 2; i++) begin
                    rd_next[i * TCC_CH1_LSB +: 8] = chfield_reg[i];
                    if (out_mode[i]) begin
                        rd_next[i * TCC_CH1_LSB + TCC_OUT_RSVD_BIT] = 1'b0;
                    end
                end
            end
            TCC_OFS_ENABLE: rd_next[7:0] = enable_reg;
            TCC_OFS_CV0: rd_next[15:0] = cv_active[0];
            TCC_OFS_CV1: rd_next[15:0] = cv_active[1];
            TCC_OFS_PROTECTION_LEVEL: rd_next[1:0] = protection_level_reg;
            TCC_OFS_STATUS: rd_next[3:0] = {filtered, prepare};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && wait_reg) begin
            AVS_READDATA <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers and filters
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            sync1_reg <= {CH1_IN, CH0_IN};
            sync2_reg <= sync1_reg;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_ch
        tcc_filter u_filter (
            .clk_sys(CLK_SYS),
            .srst(SRST),
            .din(sync2_reg[g]),
            .code(chfield_reg[g][TCC_FLT_LSB +: 4]),
            .dout(filtered[g])
        );

        tcc_compare u_compare (
            .clk_sys(CLK_SYS),
            .srst(SRST),
            .compare_control(chfield_reg[g][TCC_CTL_LSB +: 3]),
            .shadow_en(chfield_reg[g][TCC_SHADOW_BIT]),
            .fast_en(chfield_reg[g][TCC_FAST_BIT]),
            .output_mode(out_mode[g]),
            .counter_value(COUNTER_VALUE),
            .count_down(COUNT_DOWN),
            .update_event(UPDATE_EVENT),
            .trigger_edge(TRIGGER_EDGE),
            .cv_write(cv_write[g]),
            .cv_wdata(AVS_WRITEDATA[15:0]),
            .capture(capture_reg[g]),
            .prepare(prepare[g]),
            .cv_active(cv_active[g])
        );
    end

    // ------------------------------------------------------------
    // input routing and capture prescaler
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            unique case (ch_mode(chfield_reg[i]))
                TCC_MS_OWN: src_level[i] = filtered[i];
                TCC_MS_OTHER: src_level[i] = filtered[1 - i];
                TCC_MS_TRIG: src_level[i] = INTERNAL_TRIGGER_SOURCE;
                default: src_level[i] = 1'b0;
            endcase
            // polarity bit picks the falling edge instead of the rising one
            src_edge[i] = ch_pol[i] ? (src_prev_reg[i] && !src_level[i])
                                    : (!src_prev_reg[i] && src_level[i]);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            src_prev_reg <= 2'h0;
        end else begin
            src_prev_reg <= src_level;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            psc_cnt_reg[0] <= 3'h0;
            psc_cnt_reg[1] <= 3'h0;
            capture_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                capture_reg[i] <= 1'b0;
                if (!ch_en[i] || out_mode[i]) begin
                    psc_cnt_reg[i] <= 3'h0;
                end else if (src_edge[i]) begin
                    // prescale mask: 0, 1, 3 or 7 extra edges before a capture
                    if (psc_cnt_reg[i] == ((3'h1 << chfield_reg[i][TCC_PSC_LSB +: 2]) - 3'h1)) begin
                        psc_cnt_reg[i] <= 3'h0;
                        capture_reg[i] <= 1'b1;
                    end else begin
                        psc_cnt_reg[i] <= psc_cnt_reg[i] + 3'h1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output pins, idle low while the channel is disabled
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            CH0_OUTPUT_PIN <= 1'b0;
            CH0_COMPL_OUTPUT_PIN <= 1'b0;
            CH1_OUTPUT_PIN <= 1'b0;
            CH1_COMPL_OUTPUT_PIN <= 1'b0;
            CH0_CAPTURE <= 1'b0;
            CH1_CAPTURE <= 1'b0;
        end else begin
            CH0_OUTPUT_PIN <= ch_en[0] && out_mode[0] && (prepare[0] ^ ch_pol[0]);
            CH0_COMPL_OUTPUT_PIN <= ch_en[0] && out_mode[0] && (prepare[0] ^ ch_npol[0]);
            CH1_OUTPUT_PIN <= ch_en[1] && out_mode[1] && (prepare[1] ^ ch_pol[1]);
            CH1_COMPL_OUTPUT_PIN <= ch_en[1] && out_mode[1] && (prepare[1] ^ ch_npol[1]);
            CH0_CAPTURE <= capture_reg[0];
            CH1_CAPTURE <= capture_reg[1];
        end
    end

endmodule
`default_nettype wire

//--- tb/tcc_checker.sv
// bus and pin assertions for the timer channel control block
`timescale 1ns/1ps
`default_nettype none
module tcc_checker
    import tcc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic CH0_OUTPUT_PIN,
    input wire logic CH0_COMPL_OUTPUT_PIN,
    input wire logic CH0_CAPTURE,
    input wire logic CH1_CAPTURE
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    logic mapped;
    logic req;
    assign mapped = AVS_ADDRESS inside {TCC_OFS_CHCTL, TCC_OFS_ENABLE, TCC_OFS_CV0,
        TCC_OFS_CV1, TCC_OFS_PROTECTION_LEVEL, TCC_OFS_STATUS};
    assign req = AVS_READ || AVS_WRITE;
    property p_bus_rst; $fell(SRST) |-> AVS_WAITREQUEST && AVS_READDATA == 32'h0; endproperty
    a_bus_rst: assert property (p_bus_rst) else $error("bus not idle after reset");
    property p_pin_rst;
        $fell(SRST) |-> !(CH0_OUTPUT_PIN || CH0_COMPL_OUTPUT_PIN || CH0_CAPTURE || CH1_CAPTURE);
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("outputs not low after reset");
    property p_answer; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait cycle");
    property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_idle; !req |=> AVS_WAITREQUEST; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_unmapped;
        AVS_READ && AVS_WAITREQUEST && !mapped |=> AVS_READDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hold; !(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_rsvd;
        AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == TCC_OFS_CHCTL |=> AVS_READDATA[31:16] == 16'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved control bits set");
    c_wr: cover property (AVS_WRITE && !AVS_WAITREQUEST);
    c_rd: cover property (AVS_READ && !AVS_WAITREQUEST && !mapped);
    c_pin: cover property (CH0_OUTPUT_PIN ##1 !CH0_OUTPUT_PIN);
endmodule
bind tcc_top tcc_checker tcc_checker_inst (.CLK_SYS(CLK_SYS), .SRST(SRST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CH0_OUTPUT_PIN(CH0_OUTPUT_PIN), .CH0_COMPL_OUTPUT_PIN(CH0_COMPL_OUTPUT_PIN),
    .CH0_CAPTURE(CH0_CAPTURE), .CH1_CAPTURE(CH1_CAPTURE));
`default_nettype wire

//--- tb/tcc_top_tb.sv
// self-checking bench for the timer channel control block
`timescale 1ns/1ps
`default_nettype none
module tcc_top_tb;
    import tcc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rd = 1'b0, wr = 1'b0, down = 1'b0, upd = 1'b0, trig = 1'b0, in0 = 1'b0, internal_trigger_source = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    logic [15:0] cnt = 16'h0;
    logic [31:0] rdata, q;
    logic wreq, p0, n0, p1, n1, cap0, cap1;
    int n_errors = 0;
    int n_checks = 0;
    always #20 clk = ~clk;
    tcc_top tcc_top_inst (.CLK_SYS(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wreq), .COUNTER_VALUE(cnt), .COUNT_DOWN(down), .UPDATE_EVENT(upd),
        .TRIGGER_EDGE(trig), .INTERNAL_TRIGGER_SOURCE(internal_trigger_source), .CH0_IN(in0), .CH1_IN(internal_trigger_source),
        .CH0_OUTPUT_PIN(p0), .CH0_COMPL_OUTPUT_PIN(n0), .CH1_OUTPUT_PIN(p1),
        .CH1_COMPL_OUTPUT_PIN(n1), .CH0_CAPTURE(cap0), .CH1_CAPTURE(cap1));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report;
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] b);
        int i;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wreq !== 1'b0 && i < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i >= 50) chk("waitrequest", 32'h0, 32'h1);
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(n, e, q);
    endtask
    // prepare and pin latency is two cycles, four leaves margin
    task automatic pins(input logic [3:0] e);
        repeat (4) @(posedge clk);
        chk("pins", {28'h0, e}, {28'h0, p1, n1, p0, n0});
    endtask
    task automatic t_compare;
        logic [2:0] code [5] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h3};
        logic [4:0] ex = 5'b01011;
        for (int i = 0; i < 5; i++) begin
            wr32(TCC_OFS_CHCTL, {16'h0, 8'h50, 1'b0, code[i], 4'h0});
            cnt <= 16'h5;
            @(posedge clk);
            cnt <= 16'h0;
            pins({2'b11, ex[i], ex[i]});
        end
    endtask
    task automatic t_pwm;
        for (int i = 0; i < 8; i++) begin
            down <= i[1];
            cnt <= i[0] ? 16'h7 : 16'h3;
            wr32(TCC_OFS_CHCTL, 32'h5000);
            wr32(TCC_OFS_CHCTL, i[2] ? 32'h5070 : 32'h5060);
            pins({2'b11, {2{i[2] ^ !i[0]}}});
        end
    endtask
    task automatic t_fast_shadow;
        down <= 1'b0;
        cnt <= 16'h3;
        wr32(TCC_OFS_CHCTL, 32'h5000);
        wr32(TCC_OFS_CHCTL, 32'h5064);
        pins(4'hf);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        pins(4'hc);
        wr32(TCC_OFS_CHCTL, 32'h5000);
        wr32(TCC_OFS_CHCTL, 32'h5068);
        wr32(TCC_OFS_CV0, 32'h2);
        pins(4'hf);
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
        pins(4'hc);
        wr32(TCC_OFS_CHCTL, 32'h5060);
        wr32(TCC_OFS_CV0, 32'h7);
        pins(4'hf);
    endtask
    task automatic t_capture;
        int c = 0;
        wr32(TCC_OFS_PROTECTION_LEVEL, 32'h0);
        wr32(TCC_OFS_ENABLE, 32'h0);
        wr32(TCC_OFS_CHCTL, 32'h0711);
        wr32(TCC_OFS_ENABLE, 32'h11);
        cnt <= 16'h9;
        in0 <= 1'b1;
        @(posedge clk);
        in0 <= 1'b0;
        for (int i = 1; i < 5; i++) begin
            repeat (12) begin
                @(posedge clk);
                c += cap0 + 4 * cap1;
            end
            in0 <= i[0];
            internal_trigger_source <= i[0];
        end
        chk("captures", 32'h6, c);
        rdc("capture", TCC_OFS_CV0, 32'h9);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rdc("control", TCC_OFS_CHCTL, 32'h0);
        rdc("unmapped", 8'h10, 32'h0);
        wr32(TCC_OFS_CHCTL, 32'hffff5050);
        rdc("control", TCC_OFS_CHCTL, 32'h5050);
        wr32(TCC_OFS_ENABLE, 32'h11);
        pins(4'hf);
        wr32(TCC_OFS_ENABLE, 32'h13);
        pins(4'hd);
        wr32(TCC_OFS_ENABLE, 32'h11);
        wr32(TCC_OFS_CHCTL, 32'h5041);
        rdc("control", TCC_OFS_CHCTL, 32'h5040);
        pins(4'hc);
        bus(1'b1, TCC_OFS_CHCTL, 32'h5050, 4'h3);
        rdc("control", TCC_OFS_CHCTL, 32'h5040);
        wr32(TCC_OFS_CV0, 32'h5);
        t_compare;
        t_pwm;
        t_fast_shadow;
        wr32(TCC_OFS_PROTECTION_LEVEL, 32'h3);
        wr32(TCC_OFS_CHCTL, 32'h5058);
        rdc("control", TCC_OFS_CHCTL, 32'h5060);
        t_capture;
        final_report;
    end
endmodule
`default_nettype wire
